// *** src/logic_cluster_ctrl_gen.v ***
// Contract
// - The block drives three clocks, three enables, two async clears, one sync clear, one async preset/load and one sync load, at most ten active at once.
// - No more than two distinct source clocks may feed the three cluster clocks.
// - Cluster clock n is always gated by, and paired with, cluster clock enable n; here enable zero reads one while the async preset/load is in use.
// - Using both edges of one source clock takes two cluster clock outputs, one of them inverted.
// - A deasserted enable stops its paired cluster clock for every register it feeds.
// - While the async preset/load is in use, clock enable zero is not available.
// - Preset without output inversion or for power-up-high uses async load with its load data held at one.
// - Every control output is derived from the six row clocks and the local interconnect only.
// - The cluster has eight logic modules, each register chained directly to the next one's register; here each link passes through a reg_chain_out flip-flop.
`timescale 1ns/10ps
`include "logic_cluster_ctrl_defs.vh"
`default_nettype none

module logic_cluster_ctrl_gen #(
   parameter LOCAL_W = 16
) (
   input  wire                      clock,
   input  wire                      rst_n,
   input  wire [5:0]                row_clock,
   input  wire [LOCAL_W-1:0]        local_line,
   input  wire [10:0]               use_mask,
   input  wire [8:0]                clk_sel,
   input  wire [2:0]                clk_invert,
   input  wire [11:0]               ena_sel,
   input  wire [7:0]                clr_sel,
   input  wire [3:0]                sclr_sel,
   input  wire [3:0]                aload_sel,
   input  wire [3:0]                aload_data_sel,
   input  wire [3:0]                sload_sel,
   input  wire                      preset_by_load,
   input  wire [7:0]                module_reg,
   input  wire                      chain_in,
   output wire                      cluster_clock_0,
   output wire                      cluster_clock_1,
   output wire                      cluster_clock_2,
   output wire                      cluster_clock_enable_0,
   output wire                      cluster_clock_enable_1,
   output wire                      cluster_clock_enable_2,
   output wire                      cluster_async_clear_0,
   output wire                      cluster_async_clear_1,
   output reg                       cluster_sync_clear,
   output reg                       cluster_async_load,
   output reg                       cluster_async_load_data,
   output reg                       cluster_sync_load,
   output reg  [7:0]                reg_chain_out,
   output reg                       source_error,
   output reg  [3:0]                active_count
);

   reg  [2:0]                clk_q;
   reg  [2:0]                ena_out_q;
   reg  [2:0]                ena_hold_q;
   reg  [1:0]                clr_q;

   // Combinational selection and checks.
   wire [2:0]                src_raw;
   wire [2:0]                ena_raw;
   wire [2:0]                clk_used;
   reg  [1:0]                distinct;
   reg  [3:0]                count_d;
   integer                   k;

   // Codes 0 to 5 pick a row clock, 6 and 7 pick local line 0 or 1.
   function pick_clock;
      input [2:0]         sel;
      input [5:0]         rows;
      input [1:0]         locals;
      begin
         if (sel < `CLK_SEL_LOCAL_BASE) begin
            pick_clock = rows[sel];
         end else begin
            pick_clock = locals[sel[0]];
         end
      end
   endfunction

   // Clock n is in use when its bit of the use mask is set.
   assign clk_used = use_mask[`USE_CLOCK_LSB +: 3];

   // Distinct used sources; a shared source with opposite polarity still counts once.
   always @* begin
      distinct = {1'b0, clk_used[0]};
      if (clk_used[1] && !(clk_used[0] && clk_sel[5:3] == clk_sel[2:0])) begin
         distinct = distinct + 2'd1;
      end
      if (clk_used[2] && !(clk_used[0] && clk_sel[8:6] == clk_sel[2:0])
          && !(clk_used[1] && clk_sel[8:6] == clk_sel[5:3])) begin
         // Saturate at three; only the fact that there are more than two matters.
         if (distinct == 2'd3) begin
            distinct = 2'd3;
         end else begin
            distinct = distinct + 2'd1;
         end
      end
   end

   // Active control signals; enable zero does not count while the preset/load owns it.
   always @* begin
      // The count cannot pass eleven, since the use mask has eleven bits.
      count_d = `RST_COUNT;
      for (k = 0; k < `USE_W; k = k + 1) begin
         if (use_mask[k] && !(k == `USE_ENABLE_LSB && use_mask[`USE_ASYNC_LOAD])) begin
            count_d = count_d + 4'h1;
         end
      end
   end

   // One generate pass per cluster clock, then one per async clear.
   genvar n;
   generate
      for (n = 0; n < `NUM_CLUSTER_CLOCKS; n = n + 1) begin : g_clk
         // Each cluster clock is its selected source, optionally inverted, gated by its own enable.
         assign src_raw[n] = pick_clock(clk_sel[3*n +: 3], row_clock, local_line[1:0]) ^ clk_invert[n];
         // Enable zero reads one while the preset/load owns its resource.
         if (n == 0) begin : g_ena0
            assign ena_raw[n] = use_mask[`USE_ASYNC_LOAD] ? 1'b1 : local_line[ena_sel[3:0]];
         end else begin : g_enan
            assign ena_raw[n] = local_line[ena_sel[4*n +: 4]];
         end

         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               ena_hold_q[n] <= `RST_LOW;
               clk_q[n]      <= `RST_LOW;
               ena_out_q[n]  <= `RST_LOW;
            end else begin
               // The enable is taken only while the source is low, so no runt pulse leaves.
               // A source error clears every hold bit, so all cluster clocks stop at their next low phase.
               if (!src_raw[n]) begin
                  ena_hold_q[n] <= ena_raw[n] & clk_used[n] & (distinct <= `MAX_CLOCK_SOURCES);
               end
               clk_q[n]     <= src_raw[n] & ena_hold_q[n];
               ena_out_q[n] <= ena_raw[n] & clk_used[n];
            end
         end
      end

      for (n = 0; n < `NUM_ASYNC_CLEARS; n = n + 1) begin : g_clr
         // Clears are never gated by any enable.
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               clr_q[n] <= `RST_LOW;
            end else begin
               clr_q[n] <= use_mask[`USE_CLEAR_LSB + n] & local_line[clr_sel[4*n +: 4]];
            end
         end
      end
   endgenerate

   // Sync clear follows its selected local line only while it is in use.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cluster_sync_clear <= `RST_LOW;
      end else begin
         cluster_sync_clear <= use_mask[`USE_SYNC_CLEAR] & local_line[sclr_sel];
      end
   end

   // Async preset/load strobe; while it is in use enable zero is given up.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cluster_async_load <= `RST_LOW;
      end else begin
         cluster_async_load <= use_mask[`USE_ASYNC_LOAD] & local_line[aload_sel];
      end
   end

   // Load data ignores the use mask, so a preset is set up before the strobe is enabled.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cluster_async_load_data <= `RST_LOW;
      end else begin
         cluster_async_load_data <= preset_by_load | local_line[aload_data_sel];
      end
   end

   // Sync load follows its selected local line only while it is in use.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cluster_sync_load <= `RST_LOW;
      end else begin
         cluster_sync_load <= use_mask[`USE_SYNC_LOAD] & local_line[sload_sel];
      end
   end

   // Module i takes the register of module i-1; module 0 takes the chain input.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_chain_out <= `RST_CHAIN;
      end else begin
         reg_chain_out <= {module_reg[6:0], chain_in};
      end
   end

   // Source check and usage count are status only; the hold bits act on the check themselves.
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         source_error <= `RST_LOW;
         active_count <= `RST_COUNT;
      end else begin
         source_error <= (distinct > `MAX_CLOCK_SOURCES);
         active_count <= count_d;
      end
   end

   // Outputs come straight from the flip-flops above.
   assign cluster_clock_0        = clk_q[0];
   assign cluster_clock_1        = clk_q[1];
   assign cluster_clock_2        = clk_q[2];
   assign cluster_clock_enable_0 = ena_out_q[0];
   assign cluster_clock_enable_1 = ena_out_q[1];
   assign cluster_clock_enable_2 = ena_out_q[2];
   assign cluster_async_clear_0  = clr_q[0];
   assign cluster_async_clear_1  = clr_q[1];

endmodule // logic_cluster_ctrl_gen

`default_nettype wire

// *** src/logic_cluster_ctrl_defs.vh ***
`ifndef LOGIC_CLUSTER_CTRL_DEFS_VH
`define LOGIC_CLUSTER_CTRL_DEFS_VH

// Sizes of the cluster.
`define NUM_ROW_CLOCKS      6
`define NUM_CLUSTER_CLOCKS  3
`define NUM_ASYNC_CLEARS    2
`define NUM_LOGIC_MODULES   8
`define MAX_CLOCK_SOURCES   2
`define MAX_CONTROL_SIGNALS 11

// Clock source select: codes 0..5 pick a row clock, 6 and 7 pick local line 0 or 1.
`define CLK_SEL_W           3
`define CLK_SEL_LOCAL_BASE  3'h6
`define LOCAL_SEL_W         4
`define COUNT_W             4

// Positions in the use mask.
`define USE_W               11
`define USE_CLOCK_LSB       0
`define USE_ENABLE_LSB      3
`define USE_CLEAR_LSB       6
`define USE_SYNC_CLEAR      8
`define USE_ASYNC_LOAD      9
`define USE_SYNC_LOAD       10

// Reset values.
`define RST_LOW             1'b0
`define RST_COUNT           4'h0
`define RST_CHAIN           8'h00

`endif

// *** tb/logic_cluster_ctrl_gen_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module cluster_ctrl_checker (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [15:0] local_line,
   input wire logic [10:0] use_mask,
   input wire logic [7:0]  clr_sel,
   input wire logic        preset_by_load,
   input wire logic        cluster_clock_0,
   input wire logic        cluster_clock_enable_0,
   input wire logic        cluster_async_clear_0,
   input wire logic        cluster_async_load_data,
   input wire logic [3:0]  active_count,
   input wire logic [11:0] ena_sel,
   input wire logic [3:0]  aload_sel,
   input wire logic [3:0]  aload_data_sel,
   input wire logic [3:0]  sload_sel,
   input wire logic        cluster_clock_enable_1,
   input wire logic        cluster_async_clear_1,
   input wire logic        cluster_async_load,
   input wire logic        cluster_sync_load,
   input wire logic        source_error
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_off; !cluster_clock_enable_0 [*3]; endsequence
   property p_gate; s_off |-> !$rose(cluster_clock_0); endproperty
   a_gate: assert property (p_gate) else $error("gated clock rose");
   property p_ena0; use_mask[9] && use_mask[0] |=> cluster_clock_enable_0; endproperty
   a_ena0: assert property (p_ena0) else $error("enable low");
   property p_ena0_off; !use_mask[9] && !use_mask[0] |=> !cluster_clock_enable_0; endproperty
   a_ena0_off: assert property (p_ena0_off) else $error("enable high");
   property p_clr; use_mask[6] |=> cluster_async_clear_0 == $past(local_line[clr_sel[3:0]]); endproperty
   a_clr: assert property (p_clr) else $error("clear wrong");
   property p_clr_off; !use_mask[6] |=> !cluster_async_clear_0; endproperty
   a_clr_off: assert property (p_clr_off) else $error("clear high");
   property p_preset; preset_by_load |=> cluster_async_load_data; endproperty
   a_preset: assert property (p_preset) else $error("load data low");
   property p_full; use_mask == 11'h7ff |=> active_count == 4'ha; endproperty
   a_full: assert property (p_full) else $error("full count");
   property p_none; use_mask == 11'h000 |=> active_count == 4'h0; endproperty
   a_none: assert property (p_none) else $error("idle count");
   property p_ena0_sel; !use_mask[9] && use_mask[0] |=> cluster_clock_enable_0 == $past(local_line[ena_sel[3:0]]);
   endproperty
   a_ena0_sel: assert property (p_ena0_sel) else $error("enable zero wrong");
   property p_ena1_off; !use_mask[1] |=> !cluster_clock_enable_1; endproperty
   a_ena1_off: assert property (p_ena1_off) else $error("enable one high");
   property p_aload; use_mask[9] |=> cluster_async_load == $past(local_line[aload_sel]); endproperty
   a_aload: assert property (p_aload) else $error("async load wrong");
   property p_aload_off; !use_mask[9] |=> !cluster_async_load; endproperty
   a_aload_off: assert property (p_aload_off) else $error("async load high");
   property p_sload; use_mask[10] |=> cluster_sync_load == $past(local_line[sload_sel]); endproperty
   a_sload: assert property (p_sload) else $error("sync load wrong");
   property p_data; !preset_by_load |=> cluster_async_load_data == $past(local_line[aload_data_sel]); endproperty
   a_data: assert property (p_data) else $error("load data wrong");
   property p_clr1_off; !use_mask[7] |=> !cluster_async_clear_1; endproperty
   a_clr1_off: assert property (p_clr1_off) else $error("clear one high");
   sequence s_err; source_error [*3]; endsequence
   property p_err_stop; s_err |-> !$rose(cluster_clock_0); endproperty
   a_err_stop: assert property (p_err_stop) else $error("clock ran with source error");
endmodule // cluster_ctrl_checker
`default_nettype wire

// *** tb/cluster_regs_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cluster_regs_model (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       cluster_clock_0,
   input wire logic       cluster_async_clear_0,
   input wire logic [7:0] reg_chain_out,
   output var logic [7:0] module_reg
);
   logic clk_q;
   always @(posedge clock) clk_q <= cluster_clock_0;
   always @(posedge clock or negedge rst_n or posedge cluster_async_clear_0)
      if (!rst_n || cluster_async_clear_0) module_reg <= 8'h00;
      else if (cluster_clock_0 && !clk_q) module_reg <= reg_chain_out;
endmodule // cluster_regs_model
`default_nettype wire

// *** tb/logic_cluster_ctrl_gen_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module logic_cluster_ctrl_gen_tb;
   logic        clock, rst_n, preset_by_load, chain_in, cluster_clock_0, cluster_async_clear_0;
   logic        cluster_sync_clear, source_error;
   logic [5:0]  row_clock;
   logic [15:0] local_line;
   logic [10:0] use_mask;
   logic [8:0]  clk_sel;
   logic [2:0]  clk_invert;
   logic [11:0] ena_sel;
   logic [7:0]  clr_sel, module_reg, reg_chain_out;
   logic [3:0]  sclr_sel, aload_sel, aload_data_sel, sload_sel, active_count;
   logic [95:0] r;
   logic [82:0] stim;
   logic [13:0] q[$];
   int          seed, i, error_cnt, n_tests;
   wire  [13:0] got = {source_error, active_count, cluster_sync_clear, reg_chain_out};
   assign {row_clock, local_line, clk_sel, clk_invert, ena_sel, clr_sel, sclr_sel, aload_sel, aload_data_sel,
           sload_sel, preset_by_load, chain_in, use_mask} = stim;
   logic_cluster_ctrl_gen u_dut (.*, .cluster_clock_1(), .cluster_clock_2(), .cluster_clock_enable_0(),
      .cluster_clock_enable_1(), .cluster_clock_enable_2(), .cluster_async_clear_1(), .cluster_async_load(),
      .cluster_async_load_data(), .cluster_sync_load());
   cluster_regs_model u_regs (.*);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      seed = 11885;
      error_cnt = 0;
      n_tests = 0;
      rst_n = 1'b0;
      stim = '0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      for (i = 0; i < 300; i++) begin
         r = {$random(seed), $random(seed), $random(seed)};
         if (i % 30 == 0) r[10:0] = {11{i[5]}};
         stim <= r[82:0];
         @(posedge clock);
         q.push_back({&use_mask[2:0] && clk_sel[2:0] != clk_sel[5:3] && clk_sel[5:3] != clk_sel[8:6] &&
                      clk_sel[2:0] != clk_sel[8:6], 4'($countones(use_mask) - (use_mask[9] & use_mask[3])),
                      use_mask[8] & local_line[sclr_sel], module_reg[6:0], chain_in});
         @(posedge clock);
      end
      repeat (2) @(negedge clock);
      wrap_up();
   end
   always @(negedge clock)
      if (q.size() > 0) begin
         n_tests++;
         if (got !== q[0]) begin
            error_cnt++;
            $display("Error outputs expected %h seen %h", q[0], got);
         end
         q.delete(0);
      end
   task wrap_up;
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
endmodule // logic_cluster_ctrl_gen_tb
bind logic_cluster_ctrl_gen cluster_ctrl_checker u_chk (.clock, .rst_n, .local_line, .use_mask, .clr_sel,
   .preset_by_load, .cluster_clock_0, .cluster_clock_enable_0, .cluster_async_clear_0, .cluster_async_load_data,
   .active_count, .ena_sel, .aload_sel, .aload_data_sel, .sload_sel, .cluster_clock_enable_1,
   .cluster_async_clear_1, .cluster_async_load, .cluster_sync_load, .source_error);
`default_nettype wire
